//--- verilog/gioc_regs.v
/*
 * Global I/O control register bank: serial interface options and the sync clock
 * output selection. Assumes an APB master on sys_clk, a measured serial clock
 * period from the serial front end, and per-port recovered clock ready levels.
 */
`timescale 1ns/1ps
`default_nettype none
`include "gioc_map.vh"

// Behaviour
// - Preamble suppression 0: management commands need the full preamble.
// - Preamble suppression 1: management commands answered even without preamble.
// - Preamble suppression affects only the MDIO link, never SPI or I2C.
// - Automatic edge: rising at serial clock 25 MHz or faster, else falling.
// - Automatic bit 1 ignores manual bit; automatic 0 uses manual bit.
// - Manual edge 0 falling, 1 rising; resets to 0.
// - Read-only bit 7 reports the selected recovered clock ready.
// - Source field 4:2: 0 crystal, 1 to 5 port recovered clocks.
// - Sync clock output driven only while enabled; frequency 0 25 MHz, 1 125 MHz.
module gioc_regs
(
	// Clock and reset
	input  wire        sys_clk,
	input  wire        sys_rst,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [13:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// Serial front end status
	input  wire        mgmtIsMdio,
	input  wire        preambleSeen,
	input  wire [7:0]  serialClkPeriod,
	input  wire [4:0]  portClockReady,
	// Serial front end controls
	output reg         mgmtCmdAccept,
	output reg         spiOutRisingEdge,
	// Sync clock output controls
	output reg  [2:0]  syncClockSource,
	output reg         syncClockOutEnable,
	output reg         syncClockFast
);

	// Register state
	reg  [7:0]  serialCtrl;
	reg  [4:0]  outClkCtrl;
	reg         clockReady;
	reg  [1:0]  busPhase;
	// Next values
	reg  [7:0]  next_serialCtrl;
	reg  [4:0]  next_outClkCtrl;
	reg         next_clockReady;
	reg  [1:0]  next_busPhase;
	reg  [31:0] next_prdata;
	reg         next_pready;
	reg         next_pslverr;
	reg         next_mgmtCmdAccept;
	reg         next_spiOutRisingEdge;
	reg  [2:0]  next_syncClockSource;
	reg         next_syncClockOutEnable;
	reg         next_syncClockFast;
	// Decoded bus events, register fields and edge choice
	wire        setup;
	wire        access;
	wire        writeStrobe;
	wire        hitSerial;
	wire        hitOutClk;
	wire        hitAny;
	wire [2:0]  srcField;
	wire [2:0]  srcLegal;
	wire        autoRising;
	wire [7:0]  serialView;
	wire [7:0]  outClkView;

	// Bus phase tracker states
	localparam [1:0] PH_IDLE   = 2'h0;
	localparam [1:0] PH_ACCESS = 2'h1;

	// Source code reduced to a legal selection
	function [2:0] legalSource;
		input [2:0] code;
		begin
			if (code > `GIOC_SRC_LAST)
			begin
				legalSource = `GIOC_SRC_XTAL;
			end
			else
			begin
				legalSource = code;
			end
		end
	endfunction

	// Word index match on the byte address
	function indexHit;
		input [13:0] addr;
		input [11:0] index;
		begin
			indexHit = (addr[`GIOC_ADDR_IDX_HI:`GIOC_ADDR_IDX_LO] == index);
		end
	endfunction

	// Ready level behind a legal source code; the crystal counts as ready
	function portReady;
		input [2:0] code;
		input [4:0] ready;
		begin
			case (code)
				`GIOC_SRC_XTAL:
					portReady = 1'b1;
				default:
					portReady = ready[code - `GIOC_SRC_FIRST];
			endcase
		end
	endfunction

	// Bus decode
	// Low address bits are ignored, so any byte lane of a word hits it
	assign setup       = psel && !penable;
	assign access      = psel && penable && (busPhase == PH_ACCESS);
	assign writeStrobe = access && pwrite;
	assign hitSerial   = indexHit(paddr, `GIOC_IDX_SERIAL);
	assign hitOutClk   = indexHit(paddr, `GIOC_IDX_OUTCLK);
	assign hitAny      = hitSerial || hitOutClk;

	// Field decode
	// Reserved codes stay readable as written; only the output source and the ready bit fall back
	assign srcField   = outClkCtrl[`GIOC_CLK_SRC_HI:`GIOC_CLK_SRC_LO];
	assign srcLegal   = legalSource(srcField);
	assign serialView = serialCtrl;
	assign outClkView = {clockReady, `GIOC_CLK_RSVD, outClkCtrl};
	// Period in sys_clk cycles; 4 cycles at 100 MHz is 25 MHz
	// Zero means not yet measured and counts as slow, the safer edge
	// A clock near the threshold may toggle the edge; the front end
	// should only apply a change between transfers
	assign autoRising = (serialClkPeriod != `GIOC_PERIOD_NONE) &&
		(serialClkPeriod <= `GIOC_FAST_PERIOD);

	// Bus phase: an access phase always follows the setup cycle by one edge
	always @*
	begin
		next_busPhase = PH_IDLE;
		case (busPhase)
			PH_IDLE:
			begin
				if (setup)
				begin
					next_busPhase = PH_ACCESS;
				end
			end
			PH_ACCESS:
			begin
				if (setup)
				begin
					next_busPhase = PH_ACCESS;
				end
			end
			default:
			begin
				next_busPhase = PH_IDLE;
			end
		endcase
	end

	// Bus response: one wait-free access phase per transfer
	// Read data is captured at setup so it stands through the access phase
	always @*
	begin
		next_pready  = setup;
		next_pslverr = setup && !hitAny;
		next_prdata  = prdata;
		if (setup && !pwrite)
		begin
			if (hitSerial)
			begin
				next_prdata = {`GIOC_WORD_PAD, serialView};
			end
			else if (hitOutClk)
			begin
				next_prdata = {`GIOC_WORD_PAD, outClkView};
			end
			else
			begin
				next_prdata = `GIOC_WORD_ZERO;
			end
		end
	end

	// Register writes land at the access edge; unmapped writes are dropped
	always @*
	begin
		next_serialCtrl = serialCtrl;
		next_outClkCtrl = outClkCtrl;
		if (writeStrobe && hitSerial)
		begin
			next_serialCtrl = pwdata[`GIOC_SER_HI:`GIOC_SER_LO];
		end
		if (writeStrobe && hitOutClk)
		begin
			next_outClkCtrl = pwdata[`GIOC_CLK_HI:`GIOC_CLK_LO];
		end
	end

	// Only the MDIO link looks at the preamble setting
	always @*
	begin
		if (!mgmtIsMdio)
		begin
			next_mgmtCmdAccept = 1'b1;
		end
		else if (serialCtrl[`GIOC_SER_PRE_SUP])
		begin
			next_mgmtCmdAccept = 1'b1;
		end
		else
		begin
			next_mgmtCmdAccept = preambleSeen;
		end
	end

	// SPI data-out edge, automatic or manual
	always @*
	begin
		if (serialCtrl[`GIOC_SER_AUTO_EDGE])
		begin
			next_spiOutRisingEdge = autoRising;
		end
		else
		begin
			next_spiOutRisingEdge = serialCtrl[`GIOC_SER_MAN_EDGE];
		end
	end

	// Sync clock output selection and recovered clock status
	always @*
	begin
		next_syncClockSource    = srcLegal;
		next_syncClockOutEnable = outClkCtrl[`GIOC_CLK_EN];
		next_syncClockFast      = outClkCtrl[`GIOC_CLK_FREQ];
		next_clockReady         = portReady(srcLegal, portClockReady);
	end

	// Bus phase tracker
	always @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			busPhase <= PH_IDLE;
		end
		else
		begin
			busPhase <= next_busPhase;
		end
	end

	// Bus response registers
	always @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= `GIOC_WORD_ZERO;
		end
		else
		begin
			pready  <= next_pready;
			pslverr <= next_pslverr;
			prdata  <= next_prdata;
		end
	end

	// Serial I/O control register
	always @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			serialCtrl <= `GIOC_SER_RESET;
		end
		else
		begin
			serialCtrl <= next_serialCtrl;
		end
	end

	// Output clock control register
	always @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			outClkCtrl <= `GIOC_CLK_RESET;
		end
		else
		begin
			outClkCtrl <= next_outClkCtrl;
		end
	end

	// Management command gate
	always @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			mgmtCmdAccept <= 1'b0;
		end
		else
		begin
			mgmtCmdAccept <= next_mgmtCmdAccept;
		end
	end

	// SPI data-out edge
	always @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			spiOutRisingEdge <= 1'b0;
		end
		else
		begin
			spiOutRisingEdge <= next_spiOutRisingEdge;
		end
	end

	// Sync clock controls; they follow a register write by one edge
	always @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			syncClockSource    <= `GIOC_SRC_XTAL;
			syncClockOutEnable <= 1'b0;
			syncClockFast      <= 1'b0;
			clockReady         <= 1'b0;
		end
		else
		begin
			syncClockSource    <= next_syncClockSource;
			syncClockOutEnable <= next_syncClockOutEnable;
			syncClockFast      <= next_syncClockFast;
			clockReady         <= next_clockReady;
		end
	end

endmodule
`default_nettype wire

//--- verilog/gioc_map.vh
/*
 * Register map, field positions and reset values of the global I/O control bank.
 * Assumes a 32-bit APB slave; offsets are byte addresses scaled from register indices.
 */
`ifndef GIOC_MAP_VH
`define GIOC_MAP_VH

// Register indices as printed; byte address is four times the index
`define GIOC_IDX_SERIAL    12'h100
`define GIOC_IDX_OUTCLK    12'h103
`define GIOC_ADDR_SERIAL   14'h0400
`define GIOC_ADDR_OUTCLK   14'h040c
`define GIOC_ADDR_IDX_HI   13
`define GIOC_ADDR_IDX_LO   2

// Read data assembly
`define GIOC_WORD_PAD      24'h00_0000
`define GIOC_WORD_ZERO     32'h0000_0000

// Serial I/O control fields
`define GIOC_SER_RESET     8'h42
`define GIOC_SER_PRE_SUP   2
`define GIOC_SER_AUTO_EDGE 1
`define GIOC_SER_MAN_EDGE  0
`define GIOC_SER_HI        7
`define GIOC_SER_LO        0

// Output clock control fields
`define GIOC_CLK_RESET     5'h02
`define GIOC_CLK_HI        4
`define GIOC_CLK_LO        0
`define GIOC_CLK_RSVD      2'h0
`define GIOC_CLK_RDY       7
`define GIOC_CLK_SRC_HI    4
`define GIOC_CLK_SRC_LO    2
`define GIOC_CLK_EN        1
`define GIOC_CLK_FREQ      0
`define GIOC_SRC_XTAL      3'h0
`define GIOC_SRC_LAST      3'h5
`define GIOC_SRC_FIRST     3'h1

// Serial clock rate threshold for automatic edge choice
`define GIOC_FAST_MHZ      25
`define GIOC_SYS_MHZ       100
`define GIOC_FAST_PERIOD   8'h04
`define GIOC_PERIOD_NONE   8'h00

`endif

//--- sim/gioc_host.sv
/* Host status model: serial mode, preamble, clock period, port clock ready.
   Assumes the bench raises step only between bus transfers. */
`timescale 1ns/1ps
`default_nettype none
module gioc_host(
	input  wire       sys_clk, step,
	output reg        mgmtIsMdio = 0, preambleSeen = 0,
	output reg  [7:0] serialClkPeriod = 0,
	output reg  [4:0] portClockReady = 0
);
	integer    seed = 32'h4dcba087;
	reg [31:0] r;
	// Period kept in 0..15 so both sides of the edge threshold occur
	always @(posedge sys_clk)
		if (step)
		begin
			r = $random(seed);
			{mgmtIsMdio, preambleSeen, serialClkPeriod, portClockReady} <= r[14:0] & 15'h61ff;
		end
endmodule
`default_nettype wire

//--- sim/gioc_regs_chk.sv
/* Port checker of gioc_regs, shadowing both registers.
   Assumes APB writes land at the access edge. */
`timescale 1ns/1ps
`default_nettype none
module gioc_regs_chk(
	input wire        sys_clk, sys_rst, psel, penable, pwrite, pready, mgmtIsMdio,
	input wire        preambleSeen, mgmtCmdAccept, spiOutRisingEdge, syncClockOutEnable,
	input wire        syncClockFast,
	input wire [13:0] paddr,
	input wire [31:0] pwdata, prdata,
	input wire [7:0]  serialClkPeriod,
	input wire [4:0]  portClockReady,
	input wire [2:0]  syncClockSource
);
	reg  [7:0] ser;
	reg  [4:0] oc;
	reg        ok;
	wire       wr = psel && penable && pready && pwrite;
	wire [2:0] s = oc[4:2];
	wire       rdy = s == 0 || s > 5 || portClockReady[s - 3'h1];
	always @(posedge sys_clk)
	begin
		ok <= !sys_rst;
		ser <= sys_rst ? 8'h42 : wr && paddr == 14'h400 ? pwdata[7:0] : ser;
		oc <= sys_rst ? 5'h02 : wr && paddr == 14'h40c ? pwdata[4:0] : oc;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst || !ok);
	sequence s_rd; psel && penable && pready && !pwrite; endsequence
	property p_pre0; $past(mgmtIsMdio && !preambleSeen && !ser[2]) |-> !mgmtCmdAccept; endproperty
	property p_pre1; $past(mgmtIsMdio && ser[2]) |-> mgmtCmdAccept; endproperty
	property p_spi; $past(!mgmtIsMdio) |-> mgmtCmdAccept; endproperty
	property p_auto; $past(ser[1]) |-> spiOutRisingEdge ==
		$past(serialClkPeriod != 0 && serialClkPeriod <= 8'h04); endproperty
	property p_man; $past(!ser[1]) |-> spiOutRisingEdge == $past(ser[0]); endproperty
	property p_src; syncClockSource == ($past(s) > 5 ? 3'h0 : $past(s)); endproperty
	property p_en; {syncClockOutEnable, syncClockFast} == $past(oc[1:0]); endproperty
	property p_rd; s_rd and paddr == 14'h40c |-> prdata == {rdy, 2'b00, oc}; endproperty
	a_pre0: assert property (p_pre0) else $error("accept without preamble");
	a_pre1: assert property (p_pre1) else $error("refused");
	a_spi: assert property (p_spi) else $error("spi refused");
	a_auto: assert property (p_auto) else $error("auto edge");
	a_man: assert property (p_man) else $error("manual edge");
	a_src: assert property (p_src) else $error("source");
	a_en: assert property (p_en) else $error("enable or rate");
	a_rd: assert property (p_rd) else $error("clock readback");
endmodule
bind gioc_regs gioc_regs_chk chk(.*);
`default_nettype wire

//--- sim/global_io_control_regs_test.sv
/* Random APB bench of gioc_regs with gioc_host on its status inputs.
   Assumes the checker is bound to uut. */
`timescale 1ns/1ps
`default_nettype none
module global_io_control_regs_test;
	reg         sys_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, step = 0;
	reg  [13:0] paddr = 0;
	reg  [31:0] pwdata = 0, w;
	reg  [32:0] rd;
	integer     seed = 32'h4dcba087, num_errors = 0, n_tests = 0, i, k;
	wire [31:0] prdata;
	wire        pready, pslverr, mgmtIsMdio, preambleSeen, mgmtCmdAccept;
	wire        spiOutRisingEdge, syncClockOutEnable, syncClockFast;
	wire [7:0]  serialClkPeriod;
	wire [4:0]  portClockReady;
	wire [2:0]  syncClockSource;
	always #5 sys_clk = !sys_clk;
	gioc_host host(.*);
	gioc_regs uut(.*);
	task chk(input string n, input [32:0] seen, exp);
	begin
		n_tests = n_tests + 1;
		if (seen !== exp)
		begin
			num_errors = num_errors + 1;
			$display("MISMATCH %s expected %h seen %h", n, exp, seen);
		end
	end
	endtask
	function [32:0] exp_clk(input [4:0] v, input [4:0] rdy);
	begin
		exp_clk = {25'h0, v[4:2] == 0 || v[4:2] > 5 || rdy[v[4:2] - 3'h1], 2'b00, v};
	end
	endfunction
	task close_out;
	begin
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	end
	endtask
	task apb(input wr, input [13:0] a, input [31:0] d);
	begin
		@(posedge sys_clk);
		{step, psel, pwrite, paddr, pwdata} <= {2'b01, wr, a, d};
		@(posedge sys_clk);
		penable <= 1;
		for (k = 0; k < 9 && pready !== 1'b1; k = k + 1)
			@(posedge sys_clk);
		rd = {pslverr, prdata};
		{psel, penable} <= 2'b00;
		if (k == 9)
		begin
			chk("pready", 0, 1);
			close_out;
		end
	end
	endtask
	initial
	begin
		repeat (2) @(posedge sys_clk);
		sys_rst <= 0;
		apb(0, 14'h400, 0);
		chk("serial reset", rd, 33'h42);
		apb(0, 14'h40c, 0);
		chk("clock reset", rd, 33'h82);
		apb(1, 14'h408, 32'hff);
		apb(0, 14'h408, 0);
		chk("unmapped", rd, 33'h100000000);
		$display("reset test done");
		for (i = 0; i < 64; i = i + 1)
		begin
			step <= 1;
			w = $random(seed);
			w[12:10] = i < 8 ? i : w[12:10];
			apb(1, 14'h400, w);
			apb(1, 14'h40c, w >> 8);
			apb(0, 14'h400, 0);
			chk("serial", rd, w[7:0]);
			apb(0, 14'h40c, 0);
			chk("clock", rd, exp_clk(w[12:8], portClockReady));
		end
		$display("random test done");
		close_out;
	end
endmodule
`default_nettype wire
